// [include/led_strip_pkg.sv]
package led_strip_pkg;

    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS = 1000000;
    localparam int BIT_PERIOD_NS = 1280;
    localparam int DIV_STAGE_LEN = 4;
    localparam int ONE_HIGH_NS = 850;
    localparam int ZERO_HIGH_NS = 400;
    localparam int LATCH_LOW_NS = 50000;
    localparam int OSC_DIV_CYCLES =
        BIT_PERIOD_NS / (DIV_STAGE_LEN * CLK_PERIOD_NS);
    localparam logic [2:0] OSC_DIV_LAST = 3'(OSC_DIV_CYCLES - 1);
    localparam logic [4:0] ONE_HIGH_CYCLES =
        5'((ONE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] ZERO_HIGH_CYCLES =
        5'((ZERO_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // strictly longer than the latch time
    localparam logic [10:0] LATCH_GAP_CYCLES =
        11'(LATCH_LOW_NS / CLK_PERIOD_NS + 1);

    // pattern and burst
    localparam int PATTERN_WORDS = 15;
    localparam logic [8:0] PATTERN_LAST = 9'h1DF;
    localparam logic [8:0] BURST_PULSES = 9'h1F8;
    localparam logic [3:0] RING_RESET = 4'h1;

    // encoder controls
    localparam int DEBOUNCE_TAPS = 8;
    localparam logic [8:0] LONG_PRESS_MS = 9'h1F4;
    localparam logic [15:0] PERIOD_RESET_MS = 16'h0064;

    // register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] PERIOD_ADDR = 8'h08;
    localparam logic [1:0] PATTERN_PAGE = 2'h1;
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_SRC_BIT = 1;
    localparam int CTRL_KICK_BIT = 2;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ON_BIT = 1;
    localparam int STAT_SRC_BIT = 2;
    localparam int STAT_BTN_BIT = 3;
    localparam int STAT_IDX_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        BURST_IDLE = 3'h1,
        BURST_RUN = 3'h2,
        BURST_GAP = 3'h4
    } burst_state_t;

    typedef struct packed {
        logic strip_on;
        logic encoder_trigger;
    } ctrl_t;

endpackage : led_strip_pkg

// [hw/debounce_filter.sv]
`timescale 1ns/1ps
module debounce_filter
    import led_strip_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // sampling
    input wire logic sample,
    input wire logic raw,
    // filtered level
    output logic clean
);

    logic [DEBOUNCE_TAPS-1:0] taps;

    // output moves only once every tap agrees
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            taps <= '0;
            clean <= 1'b0;
        end
        else if (sample)
        begin
            taps <= {taps[DEBOUNCE_TAPS-2:0], raw};
            if (&taps)
                clean <= 1'b1;
            else if (~|taps)
                clean <= 1'b0;
        end
    end

endmodule : debounce_filter

// [hw/addressable_led_strip_driver.sv]
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module addressable_led_strip_driver
    import led_strip_pkg::*;
#(
    parameter int TICK_CYCLES = MS_NS / CLK_PERIOD_NS
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // encoder
    input wire logic enc_b,
    input wire logic enc_button_n,
    // led chain
    output logic led_data
);

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[8*i +: 8] = nw[8*i +: 8];
        return res;
    endfunction : merge

    logic [31:0] pattern [PATTERN_WORDS];
    ctrl_t ctrl;
    logic [15:0] period_ms;
    logic aw_got, w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire, wr_ctrl, wr_period, wr_pat, wr_status, kick;
    logic [3:0] wr_idx, rd_idx;
    logic [31:0] rd_value;
    logic rd_ok;
    logic [23:0] tick_cnt;
    logic tick;
    logic [1:0] raw_in, clean_in;
    logic btn_clean, b_clean, btn_prev;
    logic [8:0] press_ms;
    logic long_done, long_evt, short_evt;
    logic [15:0] period_cnt;
    logic period_level, src_level, src_prev, trig_edge;
    logic [2:0] osc_cnt;
    logic [3:0] ring;
    logic bit_clock, bit_prev, bit_rise, bit_fall;
    burst_state_t state;
    logic [8:0] pulse_cnt, ser_idx;
    logic pending, cur_bit, pattern_bit;
    logic [4:0] shot_cnt;
    logic [10:0] gap_cnt;

    // write channel: address and data taken in either order
    assign wr_fire = aw_got && w_got && !bvalid;
    assign wr_idx = waddr[5:2];
    assign wr_pat = waddr[7:6] == PATTERN_PAGE
                    && 32'(wr_idx) < PATTERN_WORDS;
    assign wr_ctrl = waddr == CTRL_ADDR;
    assign wr_period = waddr == PERIOD_ADDR;
    assign wr_status = waddr == STATUS_ADDR;
    assign kick = wr_fire && wr_ctrl && wstrb_q[0]
                  && wdata_q[CTRL_KICK_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got <= 1'b0;
            awready <= 1'b1;
            waddr <= '0;
        end
        else if (awvalid && awready)
        begin
            aw_got <= 1'b1;
            awready <= 1'b0;
            waddr <= awaddr;
        end
        else if (bvalid && bready)
        begin
            aw_got <= 1'b0;
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_got <= 1'b0;
            wready <= 1'b1;
            wdata_q <= '0;
            wstrb_q <= '0;
        end
        else if (wvalid && wready)
        begin
            w_got <= 1'b1;
            wready <= 1'b0;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end
        else if (bvalid && bready)
        begin
            w_got <= 1'b0;
            wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid <= 1'b1;
            bresp <= (wr_pat || wr_ctrl || wr_period || wr_status)
                     ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // pattern words, most significant byte of word 0 is the initial byte
    generate
        for (genvar g = 0; g < PATTERN_WORDS; g++)
        begin : g_pattern
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    pattern[g] <= '0;
                else if (wr_fire && wr_pat && 32'(wr_idx) == g)
                    pattern[g] <= merge(pattern[g], wdata_q, wstrb_q);
            end
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            period_ms <= PERIOD_RESET_MS;
        else if (wr_fire && wr_period)
            period_ms <= 16'(merge({16'h0000, period_ms}, wdata_q, wstrb_q));
    end

    // read channel, answer one cycle after the address is taken
    assign rd_idx = araddr[5:2];
    always_comb
    begin
        rd_value = '0;
        rd_ok = 1'b1;
        if (araddr[7:6] == PATTERN_PAGE && 32'(rd_idx) < PATTERN_WORDS)
            rd_value = pattern[rd_idx];
        else if (araddr == CTRL_ADDR)
        begin
            rd_value[CTRL_ON_BIT] = ctrl.strip_on;
            rd_value[CTRL_SRC_BIT] = ctrl.encoder_trigger;
        end
        else if (araddr == STATUS_ADDR)
        begin
            rd_value[STAT_BUSY_BIT] = state != BURST_IDLE;
            rd_value[STAT_ON_BIT] = ctrl.strip_on;
            rd_value[STAT_SRC_BIT] = ctrl.encoder_trigger;
            rd_value[STAT_BTN_BIT] = btn_clean;
            rd_value[STAT_IDX_LSB +: 9] = ser_idx;
        end
        else if (araddr == PERIOD_ADDR)
            rd_value[15:0] = period_ms;
        else
            rd_ok = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_value;
            rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    // millisecond tick paces the filters and the slow counters
    assign tick = tick_cnt == 24'(TICK_CYCLES - 1);
    always_ff @(posedge aclk)
    begin
        if (!aresetn || tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 24'h000001;
    end

    assign raw_in = {enc_b, ~enc_button_n};
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_debounce
            debounce_filter u_filter (
                .aclk(aclk),
                .aresetn(aresetn),
                .sample(tick),
                .raw(raw_in[g]),
                .clean(clean_in[g])
            );
        end
    endgenerate
    assign btn_clean = clean_in[0];
    assign b_clean = clean_in[1];

    // long press fires while held, so release only yields a short press
    assign long_evt = tick && btn_clean && !long_done
                      && press_ms == LONG_PRESS_MS;
    assign short_evt = btn_prev && !btn_clean && !long_done;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            btn_prev <= 1'b0;
            press_ms <= '0;
            long_done <= 1'b0;
        end
        else
        begin
            btn_prev <= btn_clean;
            if (!btn_clean)
            begin
                press_ms <= '0;
                long_done <= 1'b0;
            end
            else if (long_evt)
                long_done <= 1'b1;
            else if (tick && !long_done)
                press_ms <= press_ms + 9'h001;
        end
    end

    // two control flops; a software write wins over a button event
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl <= '{strip_on: 1'b1, encoder_trigger: 1'b0};
        else if (wr_fire && wr_ctrl && wstrb_q[0])
        begin
            ctrl.strip_on <= wdata_q[CTRL_ON_BIT];
            ctrl.encoder_trigger <= wdata_q[CTRL_SRC_BIT];
        end
        else
        begin
            if (long_evt)
                ctrl.strip_on <= !ctrl.strip_on;
            if (short_evt)
                ctrl.encoder_trigger <= !ctrl.encoder_trigger;
        end
    end

    // periodic counter held cleared while the encoder is the source
    always_ff @(posedge aclk)
    begin
        if (!aresetn || ctrl.encoder_trigger)
            period_cnt <= '0;
        else if (tick)
            period_cnt <= (period_cnt >= period_ms - 16'h0001)
                          ? 16'h0000 : period_cnt + 16'h0001;
    end
    assign period_level = period_cnt < (period_ms >> 1);

    // source switch may itself look like an edge and start a burst
    assign src_level = ctrl.encoder_trigger ? b_clean : period_level;
    assign trig_edge = (src_level && !src_prev) || kick;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            src_prev <= 1'b0;
        else
            src_prev <= src_level;
    end

    // oscillator divider then a rotating four-stage ring
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            osc_cnt <= '0;
            ring <= RING_RESET;
            bit_prev <= 1'b0;
        end
        else
        begin
            osc_cnt <= (osc_cnt == OSC_DIV_LAST) ? 3'h0 : osc_cnt + 3'h1;
            if (osc_cnt == OSC_DIV_LAST)
                ring <= {ring[2:0], ring[3]};
            bit_prev <= bit_clock;
        end
    end
    assign bit_clock = ring[0] | ring[1];
    assign bit_rise = bit_clock && !bit_prev;
    assign bit_fall = !bit_clock && bit_prev;

    // big-endian bit walk: word msb first, so each colour leaves msb first
    assign pattern_bit = pattern[ser_idx[8:5]][~ser_idx[4:0]];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= BURST_IDLE;
            pulse_cnt <= '0;
            gap_cnt <= '0;
        end
        else
        begin
            case (state)
                BURST_IDLE:
                    if (trig_edge)
                    begin
                        state <= BURST_RUN;
                        pulse_cnt <= '0;
                    end
                BURST_RUN:
                    if (bit_rise && pulse_cnt != BURST_PULSES)
                        pulse_cnt <= pulse_cnt + 9'h001;
                    else if (pulse_cnt == BURST_PULSES && !pending
                             && shot_cnt == '0)
                    begin
                        state <= BURST_GAP;
                        gap_cnt <= LATCH_GAP_CYCLES;
                    end
                BURST_GAP:
                    if (gap_cnt == 11'h001)
                        state <= BURST_IDLE;
                    else
                        gap_cnt <= gap_cnt - 11'h001;
                default:
                    state <= BURST_IDLE;
            endcase
        end
    end

    // serializer index survives bursts; that carry gives the running shift
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ser_idx <= '0;
            cur_bit <= 1'b0;
            pending <= 1'b0;
        end
        else if (state == BURST_RUN && bit_rise
                 && pulse_cnt != BURST_PULSES)
        begin
            cur_bit <= ctrl.strip_on && pattern_bit;
            pending <= 1'b1;
            ser_idx <= (ser_idx == PATTERN_LAST)
                       ? 9'h000 : ser_idx + 9'h001;
        end
        else if (bit_fall)
            pending <= 1'b0;
    end

    // one-shot: same bit clock, fired on the fall after the bit is shown
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            shot_cnt <= '0;
            led_data <= 1'b0;
        end
        else if (bit_fall && pending)
        begin
            shot_cnt <= cur_bit ? ONE_HIGH_CYCLES : ZERO_HIGH_CYCLES;
            led_data <= 1'b1;
        end
        else if (shot_cnt != '0)
        begin
            shot_cnt <= shot_cnt - 5'h01;
            led_data <= shot_cnt != 5'h01;
        end
    end

endmodule : addressable_led_strip_driver

// [verif/led_strip_checker.sv]
`timescale 1ns/1ps
module led_strip_checker
    import led_strip_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic awready,
    input wire logic arready,
    input wire logic bvalid,
    input wire logic rvalid,
    // led chain
    input wire logic led_data
);
    logic led_q;
    logic [4:0] hi_cnt;
    logic [11:0] low_cnt;
    logic [11:0] rise_gap;
    logic [9:0] pulses;
    wire rise = led_data && !led_q;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    always_ff @(posedge aclk)
        led_q <= led_data;
    always_ff @(posedge aclk)
        if (!aresetn || !led_data)
            hi_cnt <= 5'h00;
        else if (hi_cnt != 5'h1F)
            hi_cnt <= hi_cnt + 5'h01;
    always_ff @(posedge aclk)
        if (!aresetn || led_data)
            low_cnt <= 12'h000;
        else if (low_cnt != 12'hFFF)
            low_cnt <= low_cnt + 12'h001;
    // saturated after reset so the first pulse opens a burst
    always_ff @(posedge aclk)
        if (!aresetn)
            rise_gap <= 12'hFFF;
        else if (rise)
            rise_gap <= 12'h001;
        else if (rise_gap != 12'hFFF)
            rise_gap <= rise_gap + 12'h001;
    always_ff @(posedge aclk)
        if (!aresetn)
            pulses <= 10'h000;
        else if (rise)
            pulses <= (rise_gap > 12'h040) ? 10'h001 : pulses + 10'h001;

    chk_high_bounded: assert property (hi_cnt <= ONE_HIGH_CYCLES)
        else $error("led_data high too long");
    chk_high_code: assert property ($fell(led_data) |->
        hi_cnt == ONE_HIGH_CYCLES || hi_cnt == ZERO_HIGH_CYCLES)
        else $error("pulse high time is neither code");
    chk_low_time: assert property ($rose(led_data) && rise_gap == 12'h020
        |-> low_cnt == 12'h00A || low_cnt == 12'h016)
        else $error("low part of bit slot wrong");
    chk_slot_period: assert property ($rose(led_data)
        && rise_gap <= 12'h040 |-> rise_gap == 12'h020)
        else $error("bit slot not 32 cycles");
    chk_burst_length: assert property (pulses <= 10'h1F8)
        else $error("burst longer than 504 pulses");
    chk_burst_whole: assert property ($rose(led_data)
        && rise_gap > 12'h040 |-> pulses == 10'h1F8 || pulses == 10'h000)
        else $error("burst cut short");
    chk_latch_gap: assert property ($rose(led_data)
        && pulses == 10'h1F8 |-> low_cnt > 12'h4E2)
        else $error("gap between bursts too short");
    chk_reset_quiet: assert property ($rose(aresetn) |-> !led_data
        && awready && arready && !bvalid && !rvalid)
        else $error("outputs not idle after reset");

    cover property ($fell(led_data) && hi_cnt == ONE_HIGH_CYCLES);
    cover property ($fell(led_data) && hi_cnt == ZERO_HIGH_CYCLES);
    cover property ($rose(led_data) && pulses == 10'h1F8);
endmodule : led_strip_checker

bind addressable_led_strip_driver led_strip_checker i_chk (
    .aclk(aclk), .aresetn(aresetn), .awready(awready), .arready(arready),
    .bvalid(bvalid), .rvalid(rvalid), .led_data(led_data));

// [verif/led_chain_model.sv]
`timescale 1ns/1ps
module led_chain_model (
    // data line from the driver
    input wire logic led_data
);
    realtime t_rise = -1.0;
    realtime t_fall = 0.0;
    realtime hi;
    logic cur[$];
    logic frame[$];
    int frames = 0;
    int bad = 0;

    always @(posedge led_data)
        t_rise = $realtime;
    // a pulse outside both windows would be misread by a pixel
    always @(negedge led_data)
    begin
        hi = $realtime - t_rise;
        t_fall = $realtime;
        if (t_rise < 0.0)
            hi = 0.0;
        else if (hi > 250.0 && hi < 550.0)
            cur.push_back(1'b0);
        else if (hi > 700.0 && hi < 1000.0)
            cur.push_back(1'b1);
        else
            bad++;
    end
    // long low ends the frame and the pixels latch it
    always
    begin
        #1000;
        if (led_data === 1'b0 && cur.size() > 0
            && $realtime - t_fall > 50000.0)
        begin
            frame = cur;
            cur = {};
            frames++;
        end
    end
endmodule : led_chain_model

// [verif/tb_addressable_led_strip_driver.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
    failures++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_addressable_led_strip_driver
    import led_strip_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic enc_b = 1'b0;
    logic enc_button_n = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, led_data;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    int failures = 0;
    int n_tests = 0;
    logic f1[$];

    always #20 aclk = ~aclk;

    addressable_led_strip_driver #(.TICK_CYCLES(4)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .enc_b(enc_b), .enc_button_n(enc_button_n), .led_data(led_data));
    led_chain_model m (.led_data(led_data));

    task automatic wrap_up();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic hang();
        failures++;
        $display("Error wait expected done seen timeout");
        wrap_up();
    endtask : hang

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
        if (n == 50)
            hang();
    endtask : wr

    task automatic rd_reg(input logic [7:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
        if (n == 50)
            hang();
    endtask : rd_reg

    task automatic wait_frames();
        int base;
        int n;
        base = m.frames;
        for (n = 0; n < 45000; n++)
        begin
            @(posedge aclk);
            if (m.frames > base)
                break;
        end
        if (n == 45000)
            hang();
    endtask : wait_frames

    task automatic wait_idle();
        int n;
        for (n = 0; n < 9000; n++)
        begin
            rd_reg(STATUS_ADDR);
            if (rd[STAT_BUSY_BIT] === 1'b0)
                break;
        end
        if (n == 9000)
            hang();
    endtask : wait_idle

    function automatic logic [31:0] pword(input int i);
        return {8'(i), 8'hA5, 8'(8'hF0 - i), 8'h3C};
    endfunction : pword

    function automatic logic pbit(input int n);
        logic [31:0] w;
        w = pword(n / 32);
        return w[31 - n % 32];
    endfunction : pbit

    task automatic t_periodic();
        rd_reg(CTRL_ADDR);
        `CHK("ctrl", 32'h0000_0001, rd)
        rd_reg(8'h3C);
        `CHK("unmapped resp", RESP_SLVERR, resp)
        `CHK("unmapped data", 32'h0000_0000, rd)
        wr(8'h3C, 32'h0000_0001);
        `CHK("unmapped wr resp", RESP_SLVERR, resp)
        wr(PERIOD_ADDR, 32'h0000_1130);
        `CHK("period wr resp", RESP_OKAY, resp)
        rd_reg(PERIOD_ADDR);
        `CHK("period", 32'h0000_1130, rd)
        `CHK("period rd resp", RESP_OKAY, resp)
        wait_frames();
        wait_frames();
        `CHK("periodic len", 504, m.frame.size())
        `CHK("bad pulses", 0, m.bad)
        $display("periodic done");
    endtask : t_periodic

    task automatic t_rotate();
        int hits;
        int bad;
        int s;
        int i;
        wr(CTRL_ADDR, 32'h0000_0003);
        wait_idle();
        for (i = 0; i < 15; i++)
            wr(8'h40 + 8'(4 * i), pword(i));
        wr(CTRL_ADDR, 32'h0000_0007);
        wait_frames();
        f1 = m.frame;
        wait_idle();
        // three bursts of 504 so far, index wraps at 480
        `CHK("index", 9'h048, rd[STAT_IDX_LSB +: 9])
        wr(CTRL_ADDR, 32'h0000_0007);
        wait_frames();
        `CHK("len", 504, f1.size())
        bad = 0;
        for (i = 0; i < 480; i++)
            if (m.frame[i] !== f1[i + 24] || (i < 24 && f1[i] !== f1[i + 480]))
                bad++;
        `CHK("shift", 0, bad)
        hits = 0;
        for (s = 0; s < 20; s++)
        begin
            bad = 0;
            for (i = 0; i < 504; i++)
                if (f1[i] !== pbit((24 * s + i) % 480))
                    bad++;
            hits += (bad == 0);
        end
        `CHK("pattern", 1, hits)
        $display("rotate done");
    endtask : t_rotate

    task automatic t_dark();
        int i;
        int ones;
        wr(CTRL_ADDR, 32'h0000_0002);
        wait_idle();
        enc_b <= 1'b1;
        repeat (8) @(posedge aclk);
        enc_b <= 1'b0;
        repeat (100) @(posedge aclk);
        rd_reg(STATUS_ADDR);
        `CHK("glitch busy", 1'b0, rd[STAT_BUSY_BIT])
        enc_b <= 1'b1;
        repeat (100) @(posedge aclk);
        rd_reg(STATUS_ADDR);
        `CHK("encoder busy", 1'b1, rd[STAT_BUSY_BIT])
        enc_b <= 1'b0;
        wait_frames();
        ones = 0;
        for (i = 0; i < m.frame.size(); i++)
            if (m.frame[i] !== 1'b0)
                ones++;
        `CHK("dark len", 504, m.frame.size())
        `CHK("dark ones", 0, ones)
        $display("dark done");
    endtask : t_dark

    task automatic t_button();
        enc_button_n <= 1'b0;
        repeat (400) @(posedge aclk);
        rd_reg(STATUS_ADDR);
        `CHK("button level", 1'b1, rd[STAT_BTN_BIT])
        enc_button_n <= 1'b1;
        repeat (200) @(posedge aclk);
        rd_reg(CTRL_ADDR);
        `CHK("short press", 32'h0000_0000, rd)
        enc_button_n <= 1'b0;
        repeat (2400) @(posedge aclk);
        enc_button_n <= 1'b1;
        repeat (200) @(posedge aclk);
        rd_reg(CTRL_ADDR);
        `CHK("long press", 32'h0000_0001, rd)
        $display("button done");
    endtask : t_button

    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_periodic();
        t_rotate();
        t_dark();
        t_button();
        wrap_up();
    end
endmodule : tb_addressable_led_strip_driver
